// ### gpfs_top.v
// Purpose: gpio ports a to d with per-pin peripheral function select
// Assumes: classic wishbone slave, 40 MHz clk_i, synchronous reset
// Notes: pin vectors pack port a in [7:0] up to port d in [24]
`timescale 1ns/1ps
`include "gpfs_map.vh"

module gpfs_top (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [31:0] pin_in_i,
  output reg [31:0] pin_out_o,
  output reg [31:0] pin_oe_o,
  output reg [31:0] pin_hde_o,
  output reg [31:0] pin_pue_o,
  output reg [31:0] pin_smre_o,
  output reg [7:0] led_en_o,
  input wire xtal_en_i,
  input wire timer0_output_i,
  input wire timer0_in_mode_i,
  input wire timer1_output_i,
  input wire timer1_in_mode_i,
  input wire comp_out_i,
  input wire reset_drive_i,
  output reg timer0_input_o,
  output reg timer1_input_o,
  output reg ext_clock_input_o,
  output reg analog_input3_o,
  output reg [7:0] analog_sel_o,
  output reg reset_pin_o,
  output reg reset_fn_o
);

  reg [31:0] sync1_reg;
  reg [31:0] sync2_reg;
  reg [1:0] option_reg;
  wire [31:0] out_w;
  wire [31:0] dir_w;
  wire [31:0] af_w;
  wire [31:0] od_w;
  wire [31:0] hde_w;
  wire [31:0] smre_w;
  wire [31:0] pue_w;
  wire [31:0] fs1_w;
  wire [31:0] fs2_w;
  wire [31:0] rdata_w;
  wire [1:0] port_w;
  wire [1:0] reg_w;
  wire req_w;
  wire wr_w;
  wire opt_hit_w;
  wire port_hit_w;
  reg [31:0] mask_next;
  reg [31:0] out_next;
  reg [31:0] oe_next;
  reg [31:0] ctl_oe;
  reg [7:0] analog_next;
  reg [31:0] rd_next;
  integer i;

  assign port_w = adr_i[5:4];
  assign reg_w = adr_i[3:2];
  assign port_hit_w = (adr_i[7:6] == 2'b00);
  // low two address bits ignored, as on the port words
  assign opt_hit_w = ({adr_i[7:2], 2'b00} == `GPFS_OFS_OPTION);
  assign req_w = cyc_i & stb_i;
  // a write lands on the edge that the master samples ack
  assign wr_w = req_w & we_i & ack_o & sel_i[0];

  // port a has no set registers; port d wakes up in its reset function
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_port
      gpfs_port #(
        .HAS_FS((g == 0) ? 0 : 1),
        .AF_RST((g == 3) ? `GPFS_PD_AF_RST : `GPFS_ZERO_RST),
        .FS1_RST((g == 3) ? `GPFS_PD_FS1_RST : `GPFS_ZERO_RST)
      ) u_port (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_w & port_hit_w & (port_w == g)),
        .reg_i(reg_w),
        .wdata_i(dat_i[7:0]),
        .rdata_o(rdata_w[g*8+7:g*8]),
        .out_o(out_w[g*8+7:g*8]),
        .dir_o(dir_w[g*8+7:g*8]),
        .af_o(af_w[g*8+7:g*8]),
        .od_o(od_w[g*8+7:g*8]),
        .hde_o(hde_w[g*8+7:g*8]),
        .smre_o(smre_w[g*8+7:g*8]),
        .pue_o(pue_w[g*8+7:g*8]),
        .fs1_o(fs1_w[g*8+7:g*8]),
        .fs2_o(fs2_w[g*8+7:g*8])
      );
    end
  endgenerate

  // read mux
  always @*
  begin
    rd_next = 32'h00000000;
    if (opt_hit_w)
      rd_next = {30'h00000000, option_reg};
    else if (port_hit_w)
    begin
      if (reg_w == `GPFS_REG_IN)
        rd_next = {24'h000000, sync2_reg[port_w*8 +: 8]};
      else
        rd_next = {24'h000000, rdata_w[port_w*8 +: 8]};
    end
  end

  // bus slave: ack one cycle after the request is seen, dropped the next
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
      option_reg <= `GPFS_OPT_RST;
    end
    else
    begin
      ack_o <= req_w & ~ack_o;
      // data latched on the taking edge so it stands while ack is high
      if (req_w & ~ack_o)
        dat_o <= rd_next;
      if (wr_w & opt_hit_w)
        option_reg <= dat_i[1:0];
    end
  end

  // pins come from outside the clock domain
  // only the second stage feeds logic, so a metastable first stage stays contained
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= 32'h00000000;
      sync2_reg <= 32'h00000000;
    end
    else
    begin
      sync1_reg <= pin_in_i;
      sync2_reg <= sync1_reg;
    end
  end

  // pin function resolution
  always @*
  begin
    mask_next = option_reg[`GPFS_OPT_PKG28_BIT] ? `GPFS_MASK28 : `GPFS_MASK20;
    for (i = 0; i < 32; i = i + 1)
    begin
      out_next[i] = out_w[i];
      ctl_oe[i] = ~dir_w[i];
    end
    analog_next = 8'h00;
    // port a: single function, no set registers
    if (af_w[0])
    begin
      out_next[0] = ~timer0_output_i;
      ctl_oe[0] = ~timer0_in_mode_i;
    end
    if (af_w[1])
    begin
      out_next[1] = timer0_output_i;
      ctl_oe[1] = 1'b1;
    end
    for (i = 2; i < 6; i = i + 1)
      if (af_w[i])
        ctl_oe[i] = 1'b0;
    if (af_w[6])
    begin
      out_next[6] = ~timer1_output_i;
      ctl_oe[6] = ~timer1_in_mode_i;
    end
    if (af_w[7])
    begin
      out_next[7] = timer1_output_i;
      ctl_oe[7] = 1'b1;
    end
    // port b: inputs only in peripheral use
    for (i = 8; i < 16; i = i + 1)
      if (af_w[i])
        ctl_oe[i] = 1'b0;
    // analog selects stay off while the converter is disabled
    if (option_reg[`GPFS_OPT_ADC_BIT])
    begin
      analog_next[0] = af_w[8] & fs1_w[8];
      analog_next[1] = af_w[9] & fs1_w[9];
      analog_next[2] = af_w[10] & fs1_w[10];
      analog_next[3] = af_w[11] & fs1_w[11];
      analog_next[7] = af_w[12] & fs1_w[12];
      analog_next[4] = af_w[16] & fs1_w[16];
      analog_next[5] = af_w[17] & fs1_w[17];
      analog_next[6] = af_w[18] & fs1_w[18];
    end
    // port c: led sink or comparator out
    for (i = 16; i < 24; i = i + 1)
      if (af_w[i])
      begin
        out_next[i] = 1'b0;
        ctl_oe[i] = 1'b0;
      end
    if (af_w[19] & ~fs1_w[19])
    begin
      out_next[19] = comp_out_i;
      ctl_oe[19] = 1'b1;
    end
    // port d pin 0: reset pulls low only, plain io is output only
    // the far side pulls the reset line high; the device only sinks it
    if (af_w[24] & fs1_w[24])
    begin
      out_next[24] = 1'b0;
      ctl_oe[24] = reset_drive_i;
    end
    else
      ctl_oe[24] = 1'b1;
    for (i = 0; i < 32; i = i + 1)
    begin
      // open drain drives only the low level
      oe_next[i] = ctl_oe[i] & ~(od_w[i] & out_next[i]);
      // missing pins held driven low so a floating input never leaks
      if (~mask_next[i])
      begin
        out_next[i] = 1'b0;
        oe_next[i] = 1'b1;
      end
    end
    // crystal override applied last so no setting can fight the oscillator
    if (xtal_en_i)
    begin
      out_next[1:0] = 2'b00;
      oe_next[1:0] = 2'b00;
    end
  end

  // every pin control is registered, so setting changes never glitch the pins
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_out_o <= 32'h00000000;
      pin_oe_o <= 32'h00000000;
      pin_hde_o <= 32'h00000000;
      pin_pue_o <= 32'h00000000;
      pin_smre_o <= 32'h00000000;
      led_en_o <= 8'h00;
      timer0_input_o <= 1'b0;
      timer1_input_o <= 1'b0;
      ext_clock_input_o <= 1'b0;
      analog_input3_o <= 1'b0;
      analog_sel_o <= 8'h00;
      reset_pin_o <= 1'b1;
      reset_fn_o <= 1'b1;
    end
    else
    begin
      pin_out_o <= out_next;
      pin_oe_o <= oe_next;
      pin_hde_o <= hde_w & mask_next;
      pin_pue_o <= pue_w & mask_next & ~{30'h00000000, {2{xtal_en_i}}};
      pin_smre_o <= smre_w & mask_next;
      led_en_o <= af_w[23:16] & fs1_w[23:16] & mask_next[23:16];
      timer0_input_o <= af_w[0] & timer0_in_mode_i & ~xtal_en_i & sync2_reg[0];
      timer1_input_o <= af_w[6] & timer1_in_mode_i & sync2_reg[6];
      ext_clock_input_o <= af_w[11] & ~fs1_w[11] & sync2_reg[11];
      analog_input3_o <= analog_next[3];
      analog_sel_o <= analog_next;
      reset_pin_o <= (af_w[24] & fs1_w[24]) ? sync2_reg[24] : 1'b1;
      reset_fn_o <= af_w[24] & fs1_w[24];
    end
  end

endmodule // gpfs_top

// ### gpfs_map.vh
// Purpose: constants of the gpio pin function select block
// Assumes: 32-bit classic wishbone, one register per aligned word
// Notes: definitions only
`ifndef GPFS_MAP_VH
`define GPFS_MAP_VH

// per-port register words, port n at byte base n*16
`define GPFS_PORT_STRIDE 8'h10
`define GPFS_REG_ADDR 2'h0
`define GPFS_REG_CTL 2'h1
`define GPFS_REG_IN 2'h2
`define GPFS_REG_OUT 2'h3
// option word
`define GPFS_OFS_OPTION 8'h40
`define GPFS_OPT_PKG28_BIT 0
`define GPFS_OPT_ADC_BIT 1
`define GPFS_OPT_RST 2'h3

// sub-register codes seen through the address register
`define GPFS_SUB_NONE 8'h00
`define GPFS_SUB_DIR 8'h01
`define GPFS_SUB_AF 8'h02
`define GPFS_SUB_OD 8'h03
`define GPFS_SUB_HDE 8'h04
`define GPFS_SUB_SMRE 8'h05
`define GPFS_SUB_PUE 8'h06
`define GPFS_SUB_FS1 8'h07
`define GPFS_SUB_FS2 8'h08

// reset values
`define GPFS_ADDR_RST 8'h00
`define GPFS_DIR_RST 8'hFF
`define GPFS_ZERO_RST 8'h00
`define GPFS_PD_AF_RST 8'h01
`define GPFS_PD_FS1_RST 8'h01

// existing pins per package
`define GPFS_MASK28 32'h01FF3FFF
`define GPFS_MASK20 32'h010F0FFF

`endif

// ### gpfs_port.v
// Purpose: register bank of one gpio port
// Assumes: write strobe is one cycle, from the bus slave
// Notes: sub-registers reached through the address register
`timescale 1ns/1ps
`include "gpfs_map.vh"

module gpfs_port #(
  parameter HAS_FS = 1,
  parameter [7:0] AF_RST = 8'h00,
  parameter [7:0] FS1_RST = 8'h00
) (
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [1:0] reg_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  output reg [7:0] out_o,
  output reg [7:0] dir_o,
  output reg [7:0] af_o,
  output reg [7:0] od_o,
  output reg [7:0] hde_o,
  output reg [7:0] smre_o,
  output reg [7:0] pue_o,
  output reg [7:0] fs1_o,
  output reg [7:0] fs2_o
);

  reg [7:0] addr_reg;
  reg [7:0] sub_rd;

  always @*
  begin
    case (addr_reg)
      `GPFS_SUB_DIR: sub_rd = dir_o;
      `GPFS_SUB_AF: sub_rd = af_o;
      `GPFS_SUB_OD: sub_rd = od_o;
      `GPFS_SUB_HDE: sub_rd = hde_o;
      `GPFS_SUB_SMRE: sub_rd = smre_o;
      `GPFS_SUB_PUE: sub_rd = pue_o;
      `GPFS_SUB_FS1: sub_rd = (HAS_FS != 0) ? fs1_o : 8'h00;
      `GPFS_SUB_FS2: sub_rd = (HAS_FS != 0) ? fs2_o : 8'h00;
      default: sub_rd = 8'h00;
    endcase
    case (reg_i)
      `GPFS_REG_ADDR: rdata_o = addr_reg;
      `GPFS_REG_CTL: rdata_o = sub_rd;
      `GPFS_REG_OUT: rdata_o = out_o;
      default: rdata_o = 8'h00;
    endcase
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_reg <= `GPFS_ADDR_RST;
      out_o <= `GPFS_ZERO_RST;
      dir_o <= `GPFS_DIR_RST;
      af_o <= AF_RST;
      od_o <= `GPFS_ZERO_RST;
      hde_o <= `GPFS_ZERO_RST;
      smre_o <= `GPFS_ZERO_RST;
      pue_o <= `GPFS_ZERO_RST;
      fs1_o <= FS1_RST;
      fs2_o <= `GPFS_ZERO_RST;
    end
    else if (wr_i)
    begin
      if (reg_i == `GPFS_REG_ADDR)
        addr_reg <= wdata_i;
      if (reg_i == `GPFS_REG_OUT)
        out_o <= wdata_i;
      if (reg_i == `GPFS_REG_CTL)
      begin
        // code zero and unlisted codes write nothing, guarding against stray writes
        case (addr_reg)
          `GPFS_SUB_DIR: dir_o <= wdata_i;
          `GPFS_SUB_AF: af_o <= wdata_i;
          `GPFS_SUB_OD: od_o <= wdata_i;
          `GPFS_SUB_HDE: hde_o <= wdata_i;
          `GPFS_SUB_SMRE: smre_o <= wdata_i;
          `GPFS_SUB_PUE: pue_o <= wdata_i;
          `GPFS_SUB_FS1: if (HAS_FS != 0) fs1_o <= wdata_i;
          `GPFS_SUB_FS2: if (HAS_FS != 0) fs2_o <= wdata_i;
          default: addr_reg <= addr_reg;
        endcase
      end
    end
  end

endmodule // gpfs_port

// ### gpfs_props.sv
// Purpose: bus and pin relations of gpfs_top
// Assumes: option word tracked from acked bus writes
// Notes: pins 25 to 31 are not watched
`timescale 1ns/1ps
`include "gpfs_map.vh"
module gpfs_props (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire [31:0] pin_out_o,
  input wire [31:0] pin_oe_o,
  input wire [31:0] pin_pue_o,
  input wire xtal_en_i,
  input wire reset_drive_i,
  input wire reset_fn_o,
  input wire ext_clock_input_o,
  input wire analog_input3_o
);
  reg [1:0] opt_reg;
  reg [1:0] opt_d_reg;
  wire [31:0] gone;
  // opt_d_reg lags one edge, like the pin path
  assign gone = ~(opt_d_reg[0] ? `GPFS_MASK28 : `GPFS_MASK20) & 32'h01FFFFFF;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      opt_reg <= `GPFS_OPT_RST;
      opt_d_reg <= `GPFS_OPT_RST;
    end
    else
    begin
      if (cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i[7:2] == 6'h10)
        opt_reg <= dat_i[1:0];
      opt_d_reg <= opt_reg;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence ack_pulse_s;
    ack_o ##1 !ack_o;
  endsequence
  bus_ack_a: assert property (req_s |=> ack_pulse_s)
    else $error("ack not a single cycle after request");
  unmapped_zero_a: assert property (
    cyc_i && stb_i && !ack_o && !we_i && adr_i[7:2] > 6'h10 |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  data_width_a: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data above byte not zero");
  xtal_oe_a: assert property (xtal_en_i |=> pin_oe_o[1:0] == 2'h0)
    else $error("crystal pins driven");
  xtal_pull_a: assert property (xtal_en_i |=> pin_pue_o[1:0] == 2'h0)
    else $error("crystal pins pulled up");
  rst_pin_fn_a: assert property (
    reset_fn_o && $past(reset_fn_o) && !$past(rst_i)
    |-> pin_out_o[24] == 1'h0 && pin_oe_o[24] == $past(reset_drive_i))
    else $error("reset pin drive wrong");
  pd0_out_only_a: assert property (!reset_fn_o |-> pin_oe_o[24])
    else $error("port d pin 0 not output");
  missing_pin_a: assert property (
    !$past(rst_i) && opt_reg == opt_d_reg && $stable(opt_d_reg)
    |-> (pin_oe_o & gone) == gone && (pin_out_o & gone) == 32'h0)
    else $error("missing pin not driven low");
  missing_pull_a: assert property (
    !$past(rst_i) && opt_reg == opt_d_reg && $stable(opt_d_reg)
    |-> (pin_pue_o & gone) == 32'h0)
    else $error("missing pin pulled up");
  clk_or_ana_a: assert property (!(ext_clock_input_o && analog_input3_o))
    else $error("port b pin 3 has two functions");
endmodule // gpfs_props
bind gpfs_top gpfs_props props_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
  .pin_pue_o(pin_pue_o), .xtal_en_i(xtal_en_i), .reset_drive_i(reset_drive_i),
  .reset_fn_o(reset_fn_o), .ext_clock_input_o(ext_clock_input_o),
  .analog_input3_o(analog_input3_o));

// ### gpfs_board.sv
// Purpose: board circuitry on the gpio pins
// Assumes: device drive wins over the far driver
// Notes: a floating pin toggles, never a stale level
`timescale 1ns/1ps
module gpfs_board (
  input wire clk_i,
  input wire [31:0] pin_out_i,
  input wire [31:0] pin_oe_i,
  input wire [31:0] pin_pue_i,
  input wire [31:0] far_drive_i,
  input wire [31:0] far_en_i,
  output logic [31:0] pin_level_o
);
  logic noise_reg = 1'h0;
  always @(posedge clk_i)
  begin
    noise_reg <= ~noise_reg;
  end
  always_comb
  begin
    for (int k = 0; k < 32; k++)
    begin
      if (pin_oe_i[k])
        pin_level_o[k] = pin_out_i[k];
      else if (far_en_i[k])
        pin_level_o[k] = far_drive_i[k];
      else if (pin_pue_i[k])
        pin_level_o[k] = 1'h1;
      else
        pin_level_o[k] = noise_reg;
    end
  end
endmodule // gpfs_board

// ### tb.sv
// Purpose: self-checking bench of gpfs_top
// Assumes: wishbone master tasks, board model on the pins
// Notes: settle waits cover the two-flop input sync
`timescale 1ns/1ps
module tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0, xtal = 1'h0;
  logic t0_out = 1'h1, t0_mode = 1'h0, t1_out = 1'h0, rdrv = 1'h0, t1_mode = 1'h0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, v;
  wire [31:0] dat_o, pin_in, pout, poe, ppue, phde, psmre;
  wire [7:0] led, asel;
  wire ack_o, t0_in, t1_in, xclk, analog_input3, rfn, rpin;
  int n_mismatch = 0, check_count = 0, cyc_cnt = 0;
  gpfs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_in_i(pin_in), .pin_out_o(pout), .pin_oe_o(poe), .pin_hde_o(phde), .pin_pue_o(ppue),
    .pin_smre_o(psmre), .led_en_o(led), .xtal_en_i(xtal), .timer0_output_i(t0_out),
    .timer0_in_mode_i(t0_mode), .timer1_output_i(t1_out), .timer1_in_mode_i(t1_mode),
    .comp_out_i(1'h0), .reset_drive_i(rdrv), .timer0_input_o(t0_in), .timer1_input_o(t1_in),
    .ext_clock_input_o(xclk), .analog_input3_o(analog_input3), .analog_sel_o(asel), .reset_pin_o(rpin),
    .reset_fn_o(rfn));
  gpfs_board board_u (.clk_i(clk_i), .pin_out_i(pout), .pin_oe_i(poe), .pin_pue_i(ppue),
    .far_drive_i(32'h0000087D), .far_en_i(32'h000008FF), .pin_level_o(pin_in));
  initial
  begin
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic ch(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
    input logic [3:0] s);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'h1);
    v = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic sub(input logic [7:0] base, input logic [7:0] code, input logic [7:0] d);
    bus(base, 1'h1, code, 4'hF);
    bus(base + 8'h04, 1'h1, d, 4'hF);
    repeat (4) @(posedge clk_i);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    ch(rfn, 32'h1);
    bus(8'h00, 1'h0, 8'h00, 4'hF);
    ch(v, 32'h0);
    bus(8'h40, 1'h0, 8'h00, 4'hF);
    ch(v, 32'h3);
    bus(8'h08, 1'h0, 8'h00, 4'hF);
    ch(v, 32'h7D);
    $display("test reset done");
    for (int c = 0; c < 10; c++)
    begin
      sub(8'h10, c[7:0], 8'hC0 | c[7:0]);
      bus(8'h14, 1'h0, 8'h00, 4'hF);
      ch(v, (c > 0 && c < 9) ? (32'hC0 | c) : 32'h0);
    end
    ch({phde[15:8], psmre[15:8], ppue[15:8]}, 32'h040506);
    for (int c = 7; c < 9; c++)
    begin
      sub(8'h00, c[7:0], 8'hFF);
      bus(8'h04, 1'h0, 8'h00, 4'hF);
      ch(v, 32'h0);
    end
    bus(8'h10, 1'h1, 8'h55, 4'hE);
    bus(8'h10, 1'h0, 8'h00, 4'hF);
    ch(v, 32'h9);
    bus(8'h80, 1'h0, 8'h00, 4'hF);
    ch(v, 32'h0);
    $display("test codes done");
    sub(8'h20, 8'h01, 8'h00);
    bus(8'h2C, 1'h1, 8'h5A, 4'hF);
    repeat (4) @(posedge clk_i);
    ch({pout[23:16], poe[23:16]}, 32'h5AFF);
    bus(8'h28, 1'h0, 8'h00, 4'hF);
    ch(v, 32'h5A);
    sub(8'h20, 8'h03, 8'hFF);
    ch(poe[23:16], 32'hA5);
    sub(8'h20, 8'h02, 8'h0F);
    ch({poe[19:16], pout[19:16]}, 32'h80);
    sub(8'h20, 8'h07, 8'h09);
    ch({led, asel}, 32'h0912);
    $display("test plain io done");
    sub(8'h00, 8'h02, 8'hC3);
    ch({poe[7:6], pout[7:6], poe[1], pout[1]}, 32'h37);
    for (int m = 0; m < 2; m++)
    begin
      t0_mode <= m[0];
      t1_mode <= m[0];
      repeat (5) @(posedge clk_i);
      ch({poe[0], t0_in, poe[6], t1_in}, m ? 32'h5 : 32'hA);
    end
    xtal <= 1'h1;
    repeat (4) @(posedge clk_i);
    ch({poe[1:0], t0_in}, 32'h0);
    xtal <= 1'h0;
    $display("test timer done");
    sub(8'h10, 8'h02, 8'h08);
    sub(8'h10, 8'h07, 8'h00);
    ch({xclk, analog_input3}, 32'h2);
    sub(8'h10, 8'h07, 8'h08);
    ch({xclk, analog_input3}, 32'h1);
    rdrv <= 1'h1;
    repeat (5) @(posedge clk_i);
    ch({rfn, poe[24], pout[24], rpin}, 32'hC);
    sub(8'h30, 8'h02, 8'h00);
    bus(8'h3C, 1'h1, 8'h01, 4'hF);
    repeat (4) @(posedge clk_i);
    ch({rfn, poe[24], pout[24], rpin}, 32'h7);
    bus(8'h40, 1'h1, 8'h02, 4'hF);
    repeat (4) @(posedge clk_i);
    ch({poe[23:20], pout[23:20]}, 32'hF0);
    $display("test pins done");
    report_and_stop;
  end
endmodule // tb
